// ===== hw/ppp_map.svh
// Register offsets, reset values and widths of the parallel port pair.
// Assumes a CPU that reaches the registers by byte address on the special register bus.
`ifndef PPP_MAP_SVH
`define PPP_MAP_SVH

`define PPP_ADDR_W 8
`define PPP_OFS_PORT0_LATCH 8'h00
`define PPP_OFS_PORT1_LATCH 8'h01
`define PPP_OFS_PORT0_PIN 8'h08
`define PPP_OFS_PORT1_DIR 8'h0d
`define PPP_RST_PORT0_LATCH 8'hff
`define PPP_RST_PORT1_LATCH 8'h00
`define PPP_RST_PORT1_DIR 8'h00
`define PPP_RST_RDATA 8'h00
`define PPP_IRQ0_IDLE 1'b1

`endif

// ===== hw/ppp_pkg.sv
// Types shared by the parallel port pair.
// Assumes the map header sits beside this file.
`default_nettype none
`include "ppp_map.svh"

package ppp_pkg;

  localparam int PPP_W = 8;

  // CPU register request, one cycle per access.
  typedef struct packed {
    logic rd;
    logic wr;
    logic [`PPP_ADDR_W-1:0] addr;
    logic [PPP_W-1:0] wdata;
  } ppp_bus_req_t;

  // Complete state of the port pair.
  typedef struct packed {
    logic [PPP_W-1:0] p0_latch;
    logic [PPP_W-1:0] p1_latch;
    logic [PPP_W-1:0] p1_dir;
    logic [PPP_W-1:0] rdata;
    logic rd_valid;
    logic [PPP_W-1:0] p0_out;
    logic [PPP_W-1:0] p0_oe;
    logic [PPP_W-1:0] p1_out;
    logic [PPP_W-1:0] p1_oe;
    logic irq0;
  } ppp_state_t;

endpackage : ppp_pkg

`default_nettype wire

// ===== hw/ppp_ports.sv
// Two 8-bit parallel ports behind the special register bus of the CPU.
// Assumes pins and bus inputs are synchronous to clk; an external pad resolves the pin
// wire from out and oe; secondary functions hold their output at one when idle.
`default_nettype none
`include "ppp_map.svh"

module ppp_ports
  import ppp_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire ppp_bus_req_t bus_req,
  output logic [PPP_W-1:0] bus_rdata_r,
  output logic bus_rvalid_r,
  input wire logic ext_irq0_pin_select,
  input wire logic [PPP_W-1:0] port0_pin_i,
  input wire logic [PPP_W-1:0] port1_pin_i,
  input wire logic [PPP_W-1:0] port0_sec_out,
  input wire logic [PPP_W-1:0] port1_sec_out,
  output logic [PPP_W-1:0] port0_out_r,
  output logic [PPP_W-1:0] port0_oe_r,
  output logic [PPP_W-1:0] port1_out_r,
  output logic [PPP_W-1:0] port1_oe_r,
  output logic ext_irq0_input_r
);

  // ************************************************************
  // Read decode
  // ************************************************************

  // Returns the value a read of the given address produces.
  function automatic logic [PPP_W-1:0] read_value(
    input logic [`PPP_ADDR_W-1:0] addr,
    input ppp_state_t st,
    input logic [PPP_W-1:0] pin0,
    input logic [PPP_W-1:0] pin1
  );
    logic [PPP_W-1:0] v;
    v = `PPP_RST_RDATA;
    unique case (addr)
      `PPP_OFS_PORT0_LATCH: v = st.p0_latch;
      `PPP_OFS_PORT0_PIN: v = pin0;
      `PPP_OFS_PORT1_LATCH: v = (st.p1_dir & st.p1_latch) | (~st.p1_dir & pin1);
      `PPP_OFS_PORT1_DIR: v = st.p1_dir;
      default: v = `PPP_RST_RDATA;
    endcase
    return v;
  endfunction

  // ************************************************************
  // State
  // ************************************************************

  ppp_state_t s_r;
  ppp_state_t s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.rd_valid = 1'b0;
    if (bus_req.wr)
    begin
      // A read-modify-write of port 1 carries read-back pin levels of input bits into the latch.
      unique case (bus_req.addr)
        `PPP_OFS_PORT0_LATCH: s_nxt.p0_latch = bus_req.wdata;
        `PPP_OFS_PORT1_LATCH: s_nxt.p1_latch = bus_req.wdata;
        `PPP_OFS_PORT1_DIR: s_nxt.p1_dir = bus_req.wdata;
        default: s_nxt.p1_dir = s_r.p1_dir;
      endcase
    end
    if (bus_req.rd)
    begin
      s_nxt.rd_valid = 1'b1;
      s_nxt.rdata = read_value(bus_req.addr, s_r, port0_pin_i, port1_pin_i);
    end
    // Pins follow the latches at the same edge that stores the write.
    s_nxt.p0_out = s_nxt.p0_latch & port0_sec_out;
    s_nxt.p0_oe = ~s_nxt.p0_out;
    if (ext_irq0_pin_select)
    begin
      s_nxt.p0_oe[0] = 1'b0;
    end
    s_nxt.p1_out = s_nxt.p1_latch & port1_sec_out;
    s_nxt.p1_oe = s_nxt.p1_dir;
    s_nxt.irq0 = ext_irq0_pin_select ? port0_pin_i[0] : `PPP_IRQ0_IDLE;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      s_r.p0_latch <= `PPP_RST_PORT0_LATCH;
      s_r.p1_latch <= `PPP_RST_PORT1_LATCH;
      s_r.p1_dir <= `PPP_RST_PORT1_DIR;
      s_r.rdata <= `PPP_RST_RDATA;
      s_r.rd_valid <= 1'b0;
      s_r.p0_out <= `PPP_RST_PORT0_LATCH;
      s_r.p0_oe <= ~`PPP_RST_PORT0_LATCH;
      s_r.p1_out <= `PPP_RST_PORT1_LATCH;
      s_r.p1_oe <= `PPP_RST_PORT1_DIR;
      s_r.irq0 <= `PPP_IRQ0_IDLE;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign bus_rdata_r = s_r.rdata;
  assign bus_rvalid_r = s_r.rd_valid;
  assign port0_out_r = s_r.p0_out;
  assign port0_oe_r = s_r.p0_oe;
  assign port1_out_r = s_r.p1_out;
  assign port1_oe_r = s_r.p1_oe;
  assign ext_irq0_input_r = s_r.irq0;

  // ************************************************************
  // Assertions
  // ************************************************************

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  sequence p0_write_s;
    bus_req.wr && bus_req.addr == `PPP_OFS_PORT0_LATCH;
  endsequence

  sequence p1_write_s;
    bus_req.wr && bus_req.addr == `PPP_OFS_PORT1_LATCH;
  endsequence

  port0_latch_read_a: assert property (
    bus_req.rd && !bus_req.wr && bus_req.addr == `PPP_OFS_PORT0_LATCH
    |=> bus_rvalid_r && bus_rdata_r == s_r.p0_latch)
    else $error("Port0 latch read does not return the latch.");

  port0_pin_read_a: assert property (
    bus_req.rd && bus_req.addr == `PPP_OFS_PORT0_PIN
    |=> bus_rdata_r == $past(port0_pin_i))
    else $error("Port0 pin read does not return sampled pins.");

  port1_mixed_read_a: assert property (
    bus_req.rd && !bus_req.wr && bus_req.addr == `PPP_OFS_PORT1_LATCH
    |=> bus_rdata_r == ((s_r.p1_dir & s_r.p1_latch) | (~s_r.p1_dir & $past(port1_pin_i))))
    else $error("Port1 read mixes pins and latch wrongly.");

  port0_write_pins_a: assert property (
    p0_write_s |=> port0_out_r == ($past(bus_req.wdata) & $past(port0_sec_out)))
    else $error("Port0 pins did not take the written value.");

  port1_preload_a: assert property (
    p1_write_s ##1 (!bus_req.wr)[*2] |-> s_r.p1_latch == $past(bus_req.wdata, 2))
    else $error("Port1 latch lost a preload write.");

  port1_dir_oe_a: assert property (
    bus_req.wr && bus_req.addr == `PPP_OFS_PORT1_DIR |=> port1_oe_r == $past(bus_req.wdata))
    else $error("Port1 enables do not follow the direction write.");

  port0_release_a: assert property (
    s_r.p0_latch[7] && $past(port0_sec_out[7]) |-> !port0_oe_r[7])
    else $error("Port0 pin driven while latch holds one.");

  irq0_select_a: assert property (
    ext_irq0_pin_select |=> !port0_oe_r[0] && ext_irq0_input_r == $past(port0_pin_i[0]))
    else $error("Interrupt pin select not honoured.");

  irq0_idle_a: assert property (
    !ext_irq0_pin_select |=> ext_irq0_input_r)
    else $error("Interrupt input active while port bit selected.");

  reset_values_a: assert property (
    disable iff (1'b0) !rstn |=> s_r.p0_latch == 8'hff && s_r.p1_dir == 8'h00
    && s_r.p1_latch == 8'h00)
    else $error("Reset values wrong.");

  no_stray_valid_a: assert property (
    !bus_req.rd |=> !bus_rvalid_r)
    else $error("Read answer without a request.");

  cover_p0_write_c: cover property (p0_write_s ##1 bus_req.rd && bus_req.addr == 8'h00);
  cover_p1_preload_c: cover property (
    p1_write_s ##[1:4] bus_req.wr && bus_req.addr == `PPP_OFS_PORT1_DIR);
  cover_irq_sel_c: cover property (ext_irq0_pin_select ##1 !ext_irq0_input_r);
  cover_mixed_c: cover property (
    bus_req.rd && bus_req.addr == `PPP_OFS_PORT1_LATCH && s_r.p1_dir == 8'h0f);

endmodule // ppp_ports

`default_nettype wire

// ===== verif/ppp_pins.sv
// Pin model: outside sources and idle secondary functions of the port pair.
// Assumes the bench sets the level that an outside source puts on each released pin.
`default_nettype none

module ppp_pins
  import ppp_pkg::*;
(
  input wire logic [PPP_W-1:0] out0,
  input wire logic [PPP_W-1:0] oe0,
  input wire logic [PPP_W-1:0] out1,
  input wire logic [PPP_W-1:0] oe1,
  input wire logic [PPP_W-1:0] src0,
  input wire logic [PPP_W-1:0] src1,
  output logic [PPP_W-1:0] pin0,
  output logic [PPP_W-1:0] pin1,
  output logic [PPP_W-1:0] sec0,
  output logic [PPP_W-1:0] sec1
);
  timeunit 1ns;
  timeprecision 1ps;
  // Sources hold their level until the bench changes it.
  assign pin0 = (oe0 & out0) | (~oe0 & src0);
  assign pin1 = (oe1 & out1) | (~oe1 & src1);
  // Idle secondary functions hold one.
  assign sec0 = 8'hff;
  assign sec1 = 8'hff;
endmodule // ppp_pins

`default_nettype wire

// ===== verif/ppp_ports_tb.sv
// Self-checking bench of the parallel port pair.
// Assumes the pin model drives the pins and the bench acts as the CPU.
`default_nettype none

module ppp_ports_tb;
  import ppp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  ppp_bus_req_t req = '0;
  logic sel = 1'b0;
  logic [PPP_W-1:0] src0 = 8'h3c;
  logic [PPP_W-1:0] src1 = 8'h96;
  logic [PPP_W-1:0] rdata, out0, oe0, out1, oe1, pin0, pin1, sec0, sec1;
  logic rvalid, irq0;
  int miscompares = 0;
  int cmp_count = 0;

  always #25 clk = ~clk;

  ppp_ports i_ppp_ports (.clk(clk), .rstn(rstn), .bus_req(req), .bus_rdata_r(rdata),
    .bus_rvalid_r(rvalid), .ext_irq0_pin_select(sel), .port0_pin_i(pin0),
    .port1_pin_i(pin1), .port0_sec_out(sec0), .port1_sec_out(sec1), .port0_out_r(out0),
    .port0_oe_r(oe0), .port1_out_r(out1), .port1_oe_r(oe1), .ext_irq0_input_r(irq0));

  ppp_pins i_ppp_pins (.out0(out0), .oe0(oe0), .out1(out1), .oe1(oe1), .src0(src0),
    .src1(src1), .pin0(pin0), .pin1(pin1), .sec0(sec0), .sec1(sec1));

  task automatic check(input logic [PPP_W-1:0] seen, input logic [PPP_W-1:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge clk);
    #1;
    req = '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    #1;
    req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge clk);
    #1;
    req = '0;
    check({7'h00, rvalid}, 8'h01);
    check(rdata, exp);
  endtask

  task automatic t_reset();
    check(out0, 8'hff);
    check(oe0, 8'h00);
    check(out1, 8'h00);
    check(oe1, 8'h00);
    rd(8'h00, 8'hff);
    rd(8'h0d, 8'h00);
    rd(8'h01, 8'h96);
  endtask

  task automatic t_port0();
    wr(8'h00, 8'h5a);
    check(oe0, 8'ha5);
    check(pin0, 8'h18);
    wr(8'h08, 8'h00);
    rd(8'h00, 8'h5a);
    rd(8'h08, 8'h18);
    rd(8'h05, 8'h00);
    wr(8'h00, 8'hff);
    check(oe0, 8'h00);
  endtask

  task automatic t_port1();
    wr(8'h01, 8'ha5);
    check(oe1, 8'h00);
    wr(8'h0d, 8'h0f);
    check(oe1, 8'h0f);
    check(pin1, 8'h95);
    rd(8'h01, 8'h95);
    rd(8'h0d, 8'h0f);
    wr(8'h01, 8'h95);
    wr(8'h0d, 8'hff);
    check(out1, 8'h95);
  endtask

  task automatic t_irq();
    src0 = 8'h3e;
    sel = 1'b1;
    wr(8'h00, 8'hff);
    check({7'h00, irq0}, 8'h00);
    check(oe0, 8'h00);
    sel = 1'b0;
    wr(8'h00, 8'hfe);
    check({7'h00, irq0}, 8'h01);
    check(oe0, 8'h01);
  endtask

  task automatic give_verdict();
    $display("compares %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    repeat (8) @(posedge clk);
    #1;
    rstn = 1'b1;
    t_reset();
    t_port0();
    t_port1();
    t_irq();
    give_verdict();
  end

  initial
  begin
    #100us;
    miscompares++;
    give_verdict();
  end
endmodule // ppp_ports_tb

`default_nettype wire
